/* File: inc/amf_pkg.sv */
// Constants, field positions and types of the converter mode sequencer.
// Assumes all pins reach the sequencer through its own synchronisers.
package amf_pkg;
    localparam int AMF_DATA_W = 10;
    localparam int AMF_DEPTH = 8;
    localparam int AMF_PTR_W = 3;
    localparam int AMF_CNT_W = 4;
    localparam int AMF_CFG_W = 12;
    localparam int AMF_CMD_W = 4;
    localparam int AMF_CH_W = 3;
    localparam int AMF_WORD_W = 16;
    localparam int AMF_PAD_W = AMF_WORD_W - AMF_DATA_W;

    // ****************************************
    // Configuration field positions
    // ****************************************
    localparam int CFG_THR_LO = 0;
    localparam int CFG_SEQ_LO = 2;
    localparam int CFG_MODE_LO = 5;
    localparam int CFG_EXT_BIT = 7;
    localparam int CFG_EOC_BIT = 8;
    localparam int CFG_REF_BIT = 9;
    localparam logic [AMF_CFG_W-1:0] CFG_RESET = 12'h000;

    // Pin positions in the synchroniser vector
    localparam int PIN_SDI = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SS = 2;
    localparam int PIN_FS = 3;
    localparam int PIN_CS = 4;
    localparam int PIN_N = 5;

    localparam logic [3:0] BIT_CMD_LAST = 4'h3;
    localparam logic [3:0] BIT_WORD_LAST = 4'hf;
    localparam int CMD_SEL_BIT = 3;
    localparam logic [AMF_CNT_W-1:0] CNT_ONE = 4'h1;

    typedef enum logic [1:0] {
        MODE_ONE = 2'b00,
        MODE_REP = 2'b01,
        MODE_SWP = 2'b10,
        MODE_RSWP = 2'b11
    } amf_mode_t;

    typedef enum logic [3:0] {
        CMD_RD_CFG = 4'h9,
        CMD_WR_CFG = 4'ha,
        CMD_RD_FIFO = 4'he
    } amf_cmd_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SAMPLE = 2'b01,
        SEQ_CONV = 2'b10
    } amf_seq_t;

    // Fill level that raises the alert; one shot always uses one entry
    function automatic logic [AMF_CNT_W-1:0] amf_thresh(input amf_mode_t m, input logic [1:0] sel);
        logic [AMF_CNT_W-1:0] t;
        case (sel)
            2'b00: t = 4'h8;
            2'b01: t = 4'h6;
            2'b10: t = 4'h4;
            default: t = 4'h2;
        endcase
        return (m == MODE_ONE) ? CNT_ONE : t;
    endfunction : amf_thresh

    // Sweep list runs over channels 0 .. 2*(sel+1)-1
    function automatic logic [AMF_CH_W:0] amf_seq_len(input logic [1:0] sel);
        return 4'({2'b00, sel} + 4'h1) << 1;
    endfunction : amf_seq_len
endpackage : amf_pkg

/* File: inc/amf_fifo_if.sv */
// Carrier between the sequencer and its result store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface amf_fifo_if #(
    parameter int W = 10,
    parameter int CW = 4
);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic flush;
    logic [W-1:0] head;
    logic [CW-1:0] count;
    modport ctrl (output push, output wdata, output pop, output flush, input head, input count);
    modport store (input push, input wdata, input pop, input flush, output head, output count);
endinterface : amf_fifo_if

/* File: verilog/amf_fifo.sv */
// Result store: first in, first out, with flush.
// Assumes push, pop and flush come from logic on the same clock.
`timescale 1ns/10ps
module amf_fifo #(
    parameter int W = amf_pkg::AMF_DATA_W,
    parameter int DEPTH = amf_pkg::AMF_DEPTH,
    parameter int PW = amf_pkg::AMF_PTR_W,
    parameter int CW = amf_pkg::AMF_CNT_W
) (
    input wire logic mclk,
    input wire logic srst,
    amf_fifo_if.store f
);
    import amf_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
    } amf_fifo_st_t;

    amf_fifo_st_t q;
    amf_fifo_st_t d;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : step

    // Flush first, so a result pushed in the same cycle survives
    always_comb begin
        d = q;
        if (f.flush) begin
            d.rd = '0;
            d.wr = '0;
            d.cnt = '0;
        end else if (f.pop && q.cnt != '0) begin
            d.rd = step(q.rd);
            d.cnt = q.cnt - 1'b1;
        end
        if (f.push && d.cnt < CW'(DEPTH)) begin
            d.mem[d.wr] = f.wdata;
            d.wr = step(d.wr);
            d.cnt = d.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign f.head = q.mem[q.rd];
    assign f.count = q.cnt;

    // R23 depth bound
    chk_fifo_bound: assert property (@(posedge mclk) disable iff (srst) q.cnt <= CW'(DEPTH)) // R23
        else $error("fifo count above depth");
endmodule : amf_fifo

/* File: verilog/amf_sequencer.sv */
// Conversion-mode sequencer and result-store control of a serial converter.
// Assumes the analog core answers conv_start with one conv_done pulse on mclk.
// How it works
// (R1) Config bits 6:5 pick one shot, repeat, sweep or repeat sweep.
// (R2) Sweep converts each listed channel in order into the store.
// (R3) Sweep stops early once the store reaches its threshold.
// (R4) No further sweep until the host issues a store read.
// (R5) Alert rises once the store holds the threshold count.
// (R6) Repeat sweep keeps stored results when the next cycle reads them.
// (R7) Repeat sweep clears the store if the next cycle is no read.
// (R8) One shot normal: a select cycle starts select, sample, convert and read.
// (R9) One shot extended: select picks channel, sample-start pin converts.
// (R10) Host answers each result by selecting the next channel.
// (R11) Repeat mode clears the store when the alert is served without reading.
// (R12) Extended triggers come from the sample-start pin with chip select high.
// (R13) End-of-conversion pin option honoured only in one shot mode.
// (R14) Extended trigger outside one shot needs the internal reference.
// (R15) Host gives next sample-start fall within 2.5 us of select.
// (R16) Config read: decode four clocks, then shift out the config register.
// (R17) Config read accepted only in one shot mode.
// (R18) First command after alert presents oldest entry before decoding.
// (R19) A non-read there stops output but keeps the oldest entry.
// (R20) Read cycles neither convert nor signal end of conversion.
// (R21) Back-to-back 16-clock reads with frame sync high are supported.
// (R22) Write cycle loads twelve config bits without converting.
// (R23) Store is eight entries deep with a programmable threshold.
// (R24) One shot uses a single entry and ignores threshold bits.
// (R25) Host sends each command as a four-bit code first.
// (R26) Store is first in first out; alert clears once emptied.
// (R27) A write changing the mode returns the sequencer to idle.
`timescale 1ns/10ps
module amf_sequencer (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sample_start_pin_n,
    input wire logic sclk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic eoc_int_n,
    output logic conv_start,
    output logic [amf_pkg::AMF_CH_W-1:0] conv_channel,
    input wire logic conv_done,
    input wire logic [amf_pkg::AMF_DATA_W-1:0] conv_data
);
    import amf_pkg::*;

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        logic [AMF_CFG_W-1:0] cfg;
        logic [3:0] bitcnt;
        logic [AMF_WORD_W-1:0] shin;
        logic [AMF_WORD_W-1:0] shout;
        logic oe;
        logic [AMF_CMD_W-1:0] cmd;
        amf_seq_t seq;
        logic [AMF_CH_W-1:0] chan;
        logic [AMF_CH_W-1:0] pos;
        logic alert;
        logic after_alert;
        logic clr_pend;
        logic hold;
        logic start;
        logic eoc_n;
    } amf_seq_st_t;

    amf_seq_st_t q, d;
    logic push, pop, flush;

    amf_fifo_if #(.W(AMF_DATA_W), .CW(AMF_CNT_W)) ff ();

    amf_fifo #(
        .W(AMF_DATA_W),
        .DEPTH(AMF_DEPTH),
        .PW(AMF_PTR_W),
        .CW(AMF_CNT_W)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .f(ff.store)
    );

    assign ff.push = push;
    assign ff.pop = pop;
    assign ff.flush = flush;
    assign ff.wdata = conv_data;

    // ****************************************
    // Decoded pin events and fields
    // ****************************************
    amf_mode_t mode;
    logic cs_act, frame_go, sck_rise, sck_fall, ss_fall, ss_rise;
    logic dec, ext_ok, fifo_clear_mode, done_now, flush_conv;
    logic [AMF_CMD_W-1:0] cmd_now;
    logic [AMF_CNT_W-1:0] thr, lvl;

    // R1 mode decode
    assign mode = amf_mode_t'(q.cfg[CFG_MODE_LO +: 2]);
    assign cs_act = !q.s2[PIN_CS];
    assign frame_go = (cs_act && q.s3[PIN_CS]) || (cs_act && !q.s2[PIN_FS] && q.s3[PIN_FS]);
    assign sck_rise = q.s2[PIN_SCK] && !q.s3[PIN_SCK];
    assign sck_fall = !q.s2[PIN_SCK] && q.s3[PIN_SCK];
    assign ss_fall = !q.s2[PIN_SS] && q.s3[PIN_SS];
    assign ss_rise = q.s2[PIN_SS] && !q.s3[PIN_SS];
    // R25 four-bit command
    assign cmd_now = {q.shin[2:0], q.s2[PIN_SDI]};
    assign dec = cs_act && !frame_go && sck_rise && q.bitcnt == BIT_CMD_LAST;
    // R14 reference gate
    assign ext_ok = q.cfg[CFG_EXT_BIT] && (mode == MODE_ONE || q.cfg[CFG_REF_BIT]);
    assign fifo_clear_mode = (mode == MODE_REP) || (mode == MODE_RSWP);
    // R24 single entry
    assign thr = amf_thresh(mode, q.cfg[CFG_THR_LO +: 2]);
    assign done_now = q.seq == SEQ_CONV && conv_done;
    assign flush_conv = q.clr_pend || mode == MODE_ONE;
    assign lvl = flush_conv ? CNT_ONE : AMF_CNT_W'(ff.count + 1'b1);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic trig, wr_end;
        logic [AMF_CH_W:0] nxt_pos;
        trig = 1'b0;
        wr_end = 1'b0;
        nxt_pos = '0;
        d = q;
        push = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        d.s1 = {cs_n, frame_sync, sample_start_pin_n, sclk, serial_in};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.start = 1'b0;

        if (!cs_act) begin
            d.oe = 1'b0;
        end else if (frame_go) begin
            d.bitcnt = '0;
            // R18 oldest entry out early
            d.oe = ff.count != '0;
            d.shout = {ff.head, {AMF_PAD_W{1'b0}}};
        end else if (sck_rise) begin
            d.shin = {q.shin[AMF_WORD_W-2:0], q.s2[PIN_SDI]};
            d.bitcnt = q.bitcnt + 1'b1;
            if (dec) begin
                d.cmd = cmd_now;
                d.after_alert = 1'b0;
                if (cmd_now == CMD_RD_FIFO) begin
                    // R6 R26 R4 read releases
                    pop = ff.count != '0;
                    d.hold = 1'b0;
                end else if (cmd_now == CMD_RD_CFG && mode == MODE_ONE) begin
                    // R16 R17 config out
                    d.shout = {1'b0, q.cfg, 3'h0};
                    d.oe = 1'b1;
                end else if (!cmd_now[CMD_SEL_BIT] && mode == MODE_ONE) begin
                    // R8 R9 R10 select reads result
                    pop = ff.count != '0;
                    d.chan = cmd_now[AMF_CH_W-1:0];
                    trig = !ext_ok;
                end else begin
                    // R19 output stops, entry kept
                    d.oe = 1'b0;
                    // R7 R11 clear after ignored alert
                    if (q.after_alert && fifo_clear_mode) begin
                        d.clr_pend = 1'b1;
                    end
                    if (!cmd_now[CMD_SEL_BIT]) begin
                        if (mode == MODE_REP) begin
                            d.chan = cmd_now[AMF_CH_W-1:0];
                        end
                        trig = !ext_ok;
                    end
                end
            end
            if (q.bitcnt == BIT_WORD_LAST) begin
                wr_end = q.cmd == CMD_WR_CFG;
                // R21 next word of a read burst
                if (q.cmd == CMD_RD_FIFO) begin
                    d.shout = {1'b0, ff.head, {(AMF_PAD_W - 1){1'b0}}};
                    d.oe = ff.count != '0;
                end
            end
        end else if (sck_fall) begin
            d.shout = {q.shout[AMF_WORD_W-2:0], 1'b0};
        end

        // R12 extended trigger, chip select high
        if (!cs_act && ext_ok && ss_fall && q.seq == SEQ_IDLE && !q.hold) begin
            d.seq = SEQ_SAMPLE;
            d.after_alert = 1'b0;
            // R7 new trigger after alert
            if (q.after_alert && mode == MODE_RSWP) begin
                d.clr_pend = 1'b1;
            end
        end

        if ((trig && q.seq == SEQ_IDLE && !q.hold) || (q.seq == SEQ_SAMPLE && ss_rise)) begin
            d.start = 1'b1;
            d.seq = SEQ_CONV;
            // R2 channel from sweep list
            if (mode == MODE_SWP || mode == MODE_RSWP) begin
                d.chan = q.pos;
            end
        end

        // R26 alert clears when empty
        if (q.alert && ff.count == '0 && !push) begin
            d.alert = 1'b0;
        end

        if (done_now) begin
            d.seq = SEQ_IDLE;
            // R7 R11 R24 clear before storing
            push = 1'b1;
            flush = flush_conv;
            d.clr_pend = d.clr_pend && !q.clr_pend;
            // R5 threshold alert
            d.alert = (lvl >= thr) || (q.alert && !flush_conv);
            if (lvl >= thr) begin
                d.after_alert = 1'b1;
            end
            if (mode == MODE_SWP || mode == MODE_RSWP) begin
                nxt_pos = {1'b0, q.pos} + 1'b1;
                d.pos = (nxt_pos == amf_seq_len(q.cfg[CFG_SEQ_LO +: 2])) ? '0 : nxt_pos[AMF_CH_W-1:0];
                // R3 R4 sweep ends, waits for read
                if (mode == MODE_SWP && (lvl >= thr || d.pos == '0)) begin
                    d.hold = 1'b1;
                end
            end
        end

        // R22 twelve config bits, no conversion
        if (wr_end) begin
            d.cfg = {q.shin[AMF_CFG_W-2:0], q.s2[PIN_SDI]};
            // R27 mode change resets sequence
            if (d.cfg[CFG_MODE_LO +: 2] != q.cfg[CFG_MODE_LO +: 2]) begin
                d.seq = SEQ_IDLE;
                d.pos = '0;
                d.hold = 1'b0;
                d.clr_pend = 1'b0;
                d.alert = 1'b0;
                d.after_alert = 1'b0;
                push = 1'b0;
                flush = 1'b1;
            end
        end

        // R13 pin is end-of-conversion only in one shot
        if (d.cfg[CFG_MODE_LO +: 2] == MODE_ONE && d.cfg[CFG_EOC_BIT]) begin
            d.eoc_n = d.seq != SEQ_CONV;
        end else begin
            d.eoc_n = !d.alert;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '0;
            q.cfg <= CFG_RESET;
            q.seq <= SEQ_IDLE;
            q.eoc_n <= 1'b1;
            q.s1 <= '1;
            q.s2 <= '1;
            q.s3 <= '1;
        end else begin
            q <= d;
        end
    end

    assign serial_out = q.shout[AMF_WORD_W-1];
    assign serial_out_oe = q.oe;
    assign eoc_int_n = q.eoc_n;
    assign conv_start = q.start;
    assign conv_channel = q.chan;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence s_sel_one;
        dec && !cmd_now[CMD_SEL_BIT] && mode == MODE_ONE && !ext_ok && q.seq == SEQ_IDLE && !q.hold;
    endsequence
    sequence s_ext_go;
        q.seq == SEQ_SAMPLE && ss_rise;
    endsequence

    // R13 interrupt in store modes
    chk_int_in_fifo: assert property (mode != MODE_ONE |-> eoc_int_n == !q.alert) // R13
        else $error("pin does not follow alert");
    // R17 config read refused
    chk_rdcfg_gate: assert property (dec && cmd_now == CMD_RD_CFG && mode != MODE_ONE |=> !serial_out_oe) // R17
        else $error("config read outside one shot");
    // R16 config shifted out
    chk_rdcfg_data: assert property (dec && cmd_now == CMD_RD_CFG && mode == MODE_ONE
        |=> serial_out_oe && q.shout[AMF_WORD_W-2 -: AMF_CFG_W] == $past(q.cfg)) // R16
        else $error("config word not loaded");
    // R8 select starts conversion
    chk_sel_start: assert property (s_sel_one |=> conv_start && conv_channel == $past(cmd_now[AMF_CH_W-1:0])) // R8
        else $error("select did not start conversion");
    // R12 pin rise converts
    chk_ext_start: assert property (s_ext_go |=> conv_start ##1 !conv_start) // R12
        else $error("sample-start rise did not convert");
    // R20 no conversion on read or write
    chk_rw_noconv: assert property (dec && cmd_now inside {CMD_RD_CFG, CMD_RD_FIFO, CMD_WR_CFG}
        && q.seq == SEQ_IDLE |=> !conv_start) // R20
        else $error("read or write started conversion");
    // R4 hold blocks sweep
    chk_hold_block: assert property (q.hold |=> !conv_start) // R4
        else $error("sweep restarted before read");
    // R5 alert on threshold
    chk_alert_set: assert property (done_now && lvl >= thr |=> q.alert [*2] or (q.alert ##1 ff.count == '0)) // R5
        else $error("alert missing at threshold");
    // R26 alert clears when empty
    chk_alert_clr: assert property (q.alert && ff.count == '0 && !push |=> !q.alert) // R26
        else $error("alert stuck with empty store");
    // R7 clear before store
    chk_clear_first: assert property (done_now && q.clr_pend |-> flush && push) // R7
        else $error("store not cleared before result");
    // R24 one entry in one shot
    chk_one_entry: assert property (mode == MODE_ONE |-> ff.count <= CNT_ONE) // R24
        else $error("one shot holds more than one");
    // R3 sweep stops at threshold
    chk_sweep_stop: assert property (done_now && mode == MODE_SWP && lvl >= thr |=> q.hold) // R3
        else $error("sweep ran past threshold");
    // R19 non-read keeps entry
    chk_keep_entry: assert property (dec && q.after_alert && mode != MODE_ONE && cmd_now != CMD_RD_FIFO
        |-> !pop ##1 !serial_out_oe) // R19
        else $error("entry lost on non-read");
endmodule : amf_sequencer

/* File: tb/amf_host_model.sv */
// Host serial port model: frames, 16-clock words, sclk idle low.
// Assumes the bench calls its tasks and shares mclk with the sequencer.
`timescale 1ns/10ps
module amf_host_model (
    input wire logic mclk,
    output logic cs_n,
    output logic frame_sync,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic oe_seen;

    initial begin
        cs_n = 1'b1;
        frame_sync = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        oe_seen = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic open_frame();
        tick(1);
        cs_n <= 1'b0;
        oe_seen = 1'b0;
        tick(8);
    endtask : open_frame

    // command bits first, one bit per 320 ns
    task automatic bits(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        for (int i = 15; i > 15 - n; i--) begin
            serial_in <= w[i];
            tick(4);
            sclk <= 1'b1;
            r[i] = serial_out;
            if (serial_out_oe === 1'b1) begin
                oe_seen = 1'b1;
            end
            tick(4);
            sclk <= 1'b0;
        end
    endtask : bits

    // Whole 16-clock word, clock parked low after it
    task automatic word(input logic [15:0] w, output logic [15:0] r);
        bits(w, 16, r);
        tick(4);
    endtask : word

    // Frame sync restarts the frame with chip select still low
    task automatic fs_restart();
        frame_sync <= 1'b0;
        tick(8);
        frame_sync <= 1'b1;
    endtask : fs_restart

    // Released data line shows the inverse, not a stale copy
    task automatic close_frame();
        tick(1);
        cs_n <= 1'b1;
        serial_in <= ~serial_in;
        tick(12);
    endtask : close_frame
endmodule : amf_host_model

/* File: tb/testbench.sv */
// Self-checking bench of the mode sequencer with a host model.
// Assumes a behavioural analog core answering each conv_start.
`timescale 1ns/10ps
module testbench;
    import amf_pkg::*;
    logic mclk;
    logic srst;
    logic sample_start_pin_n;
    logic conv_done = 1'b0;
    logic [AMF_DATA_W-1:0] conv_data = '0;
    logic cs_n, frame_sync, sclk, serial_in, serial_out, serial_out_oe, eoc_int_n, conv_start;
    logic [AMF_CH_W-1:0] conv_channel;
    logic eoc_seen = 1'b1;
    logic [15:0] r;
    int bad_count, comparisons, n_conv, k;
    logic [AMF_DATA_W-1:0] res_q[$];
    logic [AMF_CH_W-1:0] ch_q[$];

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    amf_sequencer DUT (.mclk(mclk), .srst(srst), .cs_n(cs_n), .frame_sync(frame_sync),
        .sample_start_pin_n(sample_start_pin_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .eoc_int_n(eoc_int_n),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
        .conv_data(conv_data));

    amf_host_model u_host (.mclk(mclk), .cs_n(cs_n), .frame_sync(frame_sync), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // ****************************************
    // Analog core stand-in
    // ****************************************
    // Result carries channel and a running count so order is visible
    always begin
        @(posedge mclk);
        if (conv_start === 1'b1) begin
            n_conv++;
            ch_q.push_back(conv_channel);
            repeat (5) @(posedge mclk);
            eoc_seen <= eoc_int_n;
            repeat (5) @(posedge mclk);
            conv_data <= {conv_channel, n_conv[6:0]};
            res_q.push_back({conv_channel, n_conv[6:0]});
            conv_done <= 1'b1;
            @(posedge mclk);
            conv_done <= 1'b0;
        end
    end

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask : check_bit

    task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
        u_host.open_frame();
        u_host.word(w, rd);
        u_host.close_frame();
    endtask : xfer

    task automatic wr_cfg(input logic [11:0] v);
        logic [15:0] d;
        xfer({4'ha, v}, d);
        res_q.delete();
        ch_q.delete();
    endtask : wr_cfg

    task automatic trig(input logic [3:0] ch);
        xfer({ch, 12'h000}, r);
        u_host.tick(20);
    endtask : trig

    task automatic pin_pulse();
        u_host.tick(1);
        sample_start_pin_n <= 1'b0;
        u_host.tick(10);
        sample_start_pin_n <= 1'b1;
        u_host.tick(30);
    endtask : pin_pulse

    task automatic rd_store(input int n);
        u_host.open_frame();
        for (int i = 0; i < n; i++) begin
            u_host.word(16'he000, r);
            check_word("store word", {res_q[i], 6'h00}, r);
        end
        u_host.close_frame();
    endtask : rd_store

    task automatic end_sim();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #2_000_000;
        bad_count++;
        end_sim();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        srst = 1'b1;
        sample_start_pin_n = 1'b1;
        u_host.tick(16);
        srst <= 1'b0;
        u_host.tick(4);
        check_bit("eoc_int_n", 1'b1, eoc_int_n);
        check_bit("oe", 1'b0, serial_out_oe);
        xfer(16'h9000, r);
        check_word("cfg", 16'h0000, {4'h0, r[11:0]});
        $display("test reset done");

        wr_cfg(12'hc0f);
        xfer(16'h9000, r);
        check_word("cfg", 16'h0c0f, {4'h0, r[11:0]});
        check_word("conversions", 16'h0000, 16'(n_conv));
        $display("test config done");

        wr_cfg(12'h000);
        trig(4'h5);
        check_word("channel", 16'h0005, {13'h0000, ch_q[0]});
        check_bit("alert", 1'b0, eoc_int_n);
        trig(4'h2);
        check_word("prev result", {res_q[0], 6'h00}, r);
        wr_cfg(12'h100);
        trig(4'h1);
        check_bit("eoc low", 1'b0, eoc_seen);
        $display("test one shot done");

        wr_cfg(12'h04e);
        repeat (6) trig(4'h0);
        check_word("sweep count", 16'h0004, 16'(ch_q.size()));
        for (int i = 0; i < 4; i++) begin
            check_word("sweep channel", 16'(i), {13'h0000, ch_q[i]});
        end
        check_bit("alert", 1'b0, eoc_int_n);
        rd_store(4);
        check_bit("alert cleared", 1'b1, eoc_int_n);
        k = n_conv;
        trig(4'h0);
        check_bit("sweep restarts", 1'b1, n_conv > k);
        $display("test sweep done");

        wr_cfg(12'h063);
        trig(4'h0);
        trig(4'h0);
        check_bit("alert", 1'b0, eoc_int_n);
        // cut select, then a frame-sync frame decodes afresh
        u_host.open_frame();
        u_host.bits(16'h0000, 6, r);
        u_host.fs_restart();
        u_host.word(16'h0000, r);
        u_host.close_frame();
        u_host.tick(20);
        res_q.delete(0);
        res_q.delete(0);
        rd_store(2);
        check_bit("alert cleared", 1'b1, eoc_int_n);
        $display("test repeat sweep done");

        wr_cfg(12'h123);
        xfer(16'h9000, r);
        check_bit("cfg read refused", 1'b0, u_host.oe_seen);
        trig(4'h3);
        check_bit("int pin kept", 1'b1, eoc_seen);
        check_word("channel", 16'h0003, {13'h0000, ch_q[0]});
        $display("test repeat done");

        wr_cfg(12'h0a3);
        k = n_conv;
        pin_pulse();
        check_word("no ext conv", 16'(k), 16'(n_conv));
        wr_cfg(12'h2a3);
        pin_pulse();
        check_word("ext conv", 16'(k + 1), 16'(n_conv));
        wr_cfg(12'h080);
        k = n_conv;
        u_host.open_frame();
        u_host.bits(16'h4000, 6, r);
        // pin falls as chip select rises, inside 2.5 us
        fork
            u_host.close_frame();
            pin_pulse();
        join
        check_word("ext one shot", 16'(k + 1), 16'(n_conv));
        check_word("ext channel", 16'h0004, {13'h0000, ch_q[ch_q.size() - 1]});
        $display("test extended done");
        end_sim();
    end
endmodule : testbench
